//--- verilog/dpfh_defs.svh
// Purpose: Constants shared by both ends of the flow-control handshake
// Assumes: One bus clock at 50 MHz
// Notes:   Widths, default lengths and the zero and one count values only
`ifndef DPFH_DEFS_SVH
`define DPFH_DEFS_SVH
`define DPFH_DATA_W        32
`define DPFH_BURST_LEN     4
`define DPFH_FIFO_DEPTH    16
`define DPFH_CNT_W         8
`define DPFH_BYTE_W        8
`define DPFH_CNT_ZERO      8'h00
`define DPFH_CNT_ONE       8'h01
`endif

//--- verilog/dpfh_pkg.sv
// Purpose: Types for the flow-control handshake
// Assumes: Included defines
// Notes:   Flow-control ends (source, destination) and controller states
`include "dpfh_defs.svh"
package dpfh_pkg;
	typedef enum logic [4:0] {
		DPFH_IDLE  = 5'h01,
		DPFH_MOVE  = 5'h02,
		DPFH_ACK   = 5'h04,
		DPFH_DRAIN = 5'h08,
		DPFH_LOAD  = 5'h10
	} dpfh_state_e;
	typedef enum logic [1:0] {
		DPFH_FLOW_SRC = 2'h0,
		DPFH_FLOW_DST = 2'h1
	} dpfh_flow_e;
endpackage : dpfh_pkg

//--- verilog/dpfh_if.sv
// Purpose: Request and response wires between a peripheral and the controller
// Assumes: All signals on the bus clock
// Notes:   One modport per party
`timescale 1ns/10ps
interface dpfh_if;
	logic burst_req;
	logic single_req;
	logic last_burst_req;
	logic last_single_req;
	logic xfer_clear_ack;
	logic packet_terminal_count;
	modport ctrl (
		input  burst_req,
		input  single_req,
		input  last_burst_req,
		input  last_single_req,
		output xfer_clear_ack,
		output packet_terminal_count
	);
	modport periph (
		output burst_req,
		output single_req,
		output last_burst_req,
		output last_single_req,
		input  xfer_clear_ack,
		input  packet_terminal_count
	);
endinterface : dpfh_if

//--- verilog/dpfh_periph.sv
// Purpose: Peripheral end, raising requests under its own flow control
// Assumes: User side says how many items remain and that data is ready
// Notes:   One request per handshake, length owned by the peripheral
`timescale 1ns/10ps
`include "dpfh_defs.svh"
module dpfh_periph
	import dpfh_pkg::*;
#(
	parameter int BURST_LEN = `DPFH_BURST_LEN
) (
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	dpfh_if.periph                      link,
	input  wire logic                   ready,
	input  wire logic [`DPFH_CNT_W-1:0] remaining,
	output logic                        busy,
	output logic                        done
);
	logic req_b;
	logic req_s;
	logic req_lb;
	logic req_ls;
	logic waiting;
	logic [`DPFH_CNT_W-1:0] burst_n;
	assign burst_n = BURST_LEN[`DPFH_CNT_W-1:0];
	assign link.burst_req       = req_b;
	assign link.single_req      = req_s;
	assign link.last_burst_req  = req_lb;
	assign link.last_single_req = req_ls;
	assign busy = waiting;
	// Request held until acknowledge, then dropped; new one only after ack falls
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			req_b   <= 1'b0;
			req_s   <= 1'b0;
			req_lb  <= 1'b0;
			req_ls  <= 1'b0;
			waiting <= 1'b0;
		end else if (waiting) begin
			if (link.xfer_clear_ack) begin
				req_b   <= 1'b0;
				req_s   <= 1'b0;
				req_lb  <= 1'b0;
				req_ls  <= 1'b0;
				waiting <= 1'b0;
			end
		end else if (ready && !link.xfer_clear_ack && remaining != `DPFH_CNT_ZERO) begin
			// Exactly one line raised; kind fixed until serviced
			waiting <= 1'b1;
			if (remaining > burst_n)
				req_b <= 1'b1;
			else if (remaining == burst_n)
				req_lb <= 1'b1;
			else if (remaining == `DPFH_CNT_ONE)
				req_ls <= 1'b1;
			else
				req_s <= 1'b1;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			done <= 1'b0;
		else
			done <= link.packet_terminal_count;
	end
endmodule : dpfh_periph

//--- verilog/dpfh_ctrl.sv
// Purpose: Controller end of the peripheral flow-control handshake
// Assumes: Bus transfers abstracted as one beat per cycle when allowed
// Notes:   FIFO is an occupancy count; data path lives elsewhere
//
// Summary of operation
// - Peripheral keeps burst and last-burst exclusive
// - Peripheral keeps single and last-single exclusive
// - Four request lines exclusive, no upgrades
// - No length count; one transfer per request
// - Peripheral picks burst, last-burst, single, last-single
// - Last request transfer then load next descriptor
// - Source reads only when FIFO has room
// - No source reads after last until load, except the end of a fetch already started in destination flow
// - Destination writes need request and enough data
// - Drain FIFO in bursts, then load descriptor
// - Destination flow: fetch only on destination demand
// - Destination last: fetch, write, then load
// - Leftover narrow-destination bytes discarded
// - Requests active high, sampled on clock edge
// - Peripheral holds request until acknowledge
// - Acknowledge after last item, drop after request
// - Terminal count marks end of packet
// - Selected requests pass a synchroniser
// - Terminal count, then next descriptor
`timescale 1ns/10ps
`include "dpfh_defs.svh"
module dpfh_ctrl
	import dpfh_pkg::*;
#(
	parameter int BURST_LEN  = `DPFH_BURST_LEN,
	parameter int FIFO_DEPTH = `DPFH_FIFO_DEPTH
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	dpfh_if.ctrl                  flow,
	dpfh_if.ctrl                  peer,
	input  wire logic             flow_is_dst,
	input  wire logic [1:0]       req_sync_select,
	input  wire logic             bus_ready,
	output logic                  src_read,
	output logic                  dst_write,
	output logic                  descriptor_load,
	output logic [`DPFH_CNT_W-1:0] fifo_level,
	output logic [`DPFH_CNT_W-1:0] discarded
);
	dpfh_state_e state;
	logic [3:0] f_s1, f_s2, p_s1, p_s2;
	logic [3:0] f_req, p_req;
	logic [`DPFH_CNT_W-1:0] beats;
	logic last_seen;
	logic src_busy;
	logic [`DPFH_CNT_W-1:0] fetch_left;
	logic fetch_start;
	logic [`DPFH_CNT_W-1:0] burst_n;
	logic [`DPFH_CNT_W-1:0] depth_n;
	assign burst_n = BURST_LEN[`DPFH_CNT_W-1:0];
	assign depth_n = FIFO_DEPTH[`DPFH_CNT_W-1:0];

	function automatic logic [3:0] pack(input logic b, input logic s,
		input logic lb, input logic ls);
		pack = {ls, lb, s, b};
	endfunction : pack

	function automatic logic [`DPFH_CNT_W-1:0] size_of(input logic [3:0] r,
		input logic [`DPFH_CNT_W-1:0] bl);
		size_of = (r[0] | r[2]) ? bl : `DPFH_CNT_ONE;
	endfunction : size_of

	// Two-flop path for requests from another clock domain
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			f_s1 <= 4'h0;
			f_s2 <= 4'h0;
			p_s1 <= 4'h0;
			p_s2 <= 4'h0;
		end else begin
			f_s1 <= pack(flow.burst_req, flow.single_req, flow.last_burst_req, flow.last_single_req);
			f_s2 <= f_s1;
			p_s1 <= pack(peer.burst_req, peer.single_req, peer.last_burst_req, peer.last_single_req);
			p_s2 <= p_s1;
		end
	end
	// Sync adds two cycles of latency, so only enable when clocks differ
	assign f_req = req_sync_select[0] ? f_s2 : pack(flow.burst_req, flow.single_req,
		flow.last_burst_req, flow.last_single_req);
	assign p_req = req_sync_select[1] ? p_s2 : pack(peer.burst_req, peer.single_req,
		peer.last_burst_req, peer.last_single_req);

	logic fifo_room;
	logic fifo_enough;
	logic src_avail;
	assign fifo_room   = (depth_n - fifo_level) >= beats;
	assign fifo_enough = fifo_level >= burst_n;
	assign src_avail   = p_req[0] | p_req[1];
	// New fetch only when the FIFO is empty and the destination is owed data
	assign fetch_start = flow_is_dst && state == DPFH_MOVE && bus_ready
		&& beats != `DPFH_CNT_ZERO && fifo_level == `DPFH_CNT_ZERO
		&& fetch_left == `DPFH_CNT_ZERO && src_avail;

	// Beat enables per flow-control mode
	always_comb begin
		src_read  = 1'b0;
		dst_write = 1'b0;
		if (flow_is_dst) begin
			// A started fetch runs to its end, even past the acknowledge
			src_read = bus_ready && fetch_left != `DPFH_CNT_ZERO;
			if (state == DPFH_MOVE && bus_ready)
				dst_write = fifo_level != `DPFH_CNT_ZERO && beats != `DPFH_CNT_ZERO;
		end else if (state == DPFH_MOVE && bus_ready) begin
			src_read  = src_busy && fifo_room && beats != `DPFH_CNT_ZERO;
			dst_write = !src_read && p_req[0] && fifo_enough;
		end else if (state == DPFH_DRAIN && bus_ready) begin
			dst_write = fifo_level != `DPFH_CNT_ZERO && (p_req[0] || p_req[2]);
		end
	end

	// Fetch sized by what the source offers; a burst may overshoot the need
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fetch_left <= `DPFH_CNT_ZERO;
		end else if (src_read && flow_is_dst) begin
			fetch_left <= fetch_left - `DPFH_CNT_ONE;
		end else if (fetch_start) begin
			fetch_left <= size_of(p_req, burst_n);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state     <= DPFH_IDLE;
			beats     <= `DPFH_CNT_ZERO;
			last_seen <= 1'b0;
			src_busy  <= 1'b0;
		end else begin
			case (state)
				DPFH_IDLE: begin
					if (f_req != 4'h0) begin
						// One transfer sized by the request kind only
						beats     <= size_of(f_req, burst_n);
						last_seen <= f_req[2] | f_req[3];
						src_busy  <= 1'b1;
						state     <= DPFH_MOVE;
					end
				end
				DPFH_MOVE: begin
					if (!flow_is_dst) begin
						if (src_read)
							beats <= beats - `DPFH_CNT_ONE;
						if (src_read && beats == `DPFH_CNT_ONE) begin
							src_busy <= 1'b0;
							state    <= DPFH_ACK;
						end
					end else if (dst_write) begin
						beats <= beats - `DPFH_CNT_ONE;
						if (beats == `DPFH_CNT_ONE)
							state <= DPFH_ACK;
					end
				end
				DPFH_ACK: begin
					if (f_req == 4'h0) begin
						if (!last_seen)
							state <= DPFH_IDLE;
						else if (!flow_is_dst && fifo_level != `DPFH_CNT_ZERO)
							state <= DPFH_DRAIN;
						else if (flow_is_dst && fetch_left != `DPFH_CNT_ZERO)
							state <= DPFH_DRAIN;
						else
							state <= DPFH_LOAD;
					end
				end
				DPFH_DRAIN: begin
					// Destination flow waits only for the source fetch to end
					if (flow_is_dst && fetch_left == `DPFH_CNT_ZERO)
						state <= DPFH_LOAD;
					else if (!flow_is_dst && (fifo_level == `DPFH_CNT_ZERO
						|| (dst_write && fifo_level == `DPFH_CNT_ONE)))
						state <= DPFH_LOAD;
				end
				DPFH_LOAD: begin
					last_seen <= 1'b0;
					state     <= DPFH_IDLE;
				end
				default: state <= DPFH_IDLE;
			endcase
		end
	end

	// Occupancy; leftover bytes dropped when a descriptor is loaded
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fifo_level <= `DPFH_CNT_ZERO;
			discarded  <= `DPFH_CNT_ZERO;
		end else if (state == DPFH_LOAD) begin
			discarded  <= fifo_level;
			fifo_level <= `DPFH_CNT_ZERO;
		end else if (src_read && !dst_write) begin
			fifo_level <= fifo_level + `DPFH_CNT_ONE;
		end else if (dst_write && !src_read) begin
			fifo_level <= fifo_level - `DPFH_CNT_ONE;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			descriptor_load <= 1'b0;
		end else begin
			descriptor_load <= state == DPFH_LOAD;
		end
	end

	assign flow.xfer_clear_ack        = state == DPFH_ACK;
	assign flow.packet_terminal_count = state == DPFH_ACK && last_seen;
	assign peer.xfer_clear_ack        = dst_write; // One pulse per beat to the peer
	assign peer.packet_terminal_count = state == DPFH_LOAD;
endmodule : dpfh_ctrl

//--- dv/dpfh_chk.sv
// Purpose: Handshake checks on the flow-controlling link
// Assumes: One clock, rst_n async low
// Notes:   Both ends are design, so both sides are watched
`timescale 1ns/10ps
module dpfh_chk (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic burst_req,
	input wire logic single_req,
	input wire logic last_burst_req,
	input wire logic last_single_req,
	input wire logic xfer_clear_ack,
	input wire logic packet_terminal_count,
	input wire logic req_synced
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire any_req  = burst_req | single_req | last_burst_req | last_single_req;
	wire any_last = last_burst_req | last_single_req;
	chk_req_one_hot: assert property (
		$onehot0({burst_req, single_req, last_burst_req, last_single_req}))
		else $error("request lines overlap");
	chk_req_held_ack: assert property (
		(any_req && !xfer_clear_ack) |=> any_req) else $error("request dropped early");
	chk_req_drop_ack: assert property (
		$rose(xfer_clear_ack) |-> ##[1:2] !any_req) else $error("request kept after ack");
	chk_ack_has_cause: assert property (
		$rose(xfer_clear_ack) |-> $past(any_req)) else $error("ack without request");
	chk_ack_release: assert property (
		(xfer_clear_ack && !any_req && !req_synced) |=> !xfer_clear_ack)
		else $error("ack stuck");
	chk_ack_release_sync: assert property (
		(xfer_clear_ack && !any_req && req_synced) |-> ##[1:3] !xfer_clear_ack)
		else $error("synced ack stuck");
	chk_ack_min_wait: assert property (
		$rose(any_req) |-> !xfer_clear_ack [*2]) else $error("ack before data moved");
	chk_new_req_gap: assert property (
		$rose(any_req) |-> !$past(xfer_clear_ack)) else $error("request while ack high");
	chk_tc_on_last: assert property (
		$rose(packet_terminal_count) |-> xfer_clear_ack && $past(any_last))
		else $error("terminal count without last request");
	chk_last_gives_tc: assert property (
		($rose(xfer_clear_ack) && $past(any_last)) |-> packet_terminal_count)
		else $error("last request without terminal count");
	cover property ($rose(xfer_clear_ack) && $past(last_burst_req));
	cover property ($rose(xfer_clear_ack) && $past(last_single_req));
	cover property ($rose(xfer_clear_ack) && $past(single_req));
endmodule : dpfh_chk

//--- dv/dma_periph_flow_handshake_tb.sv
// Purpose: Bench for both ends of the flow handshake
// Assumes: bus_ready held high, peer lines driven here
// Notes:   Beats counted from the one-cycle pulses
`timescale 1ns/10ps
`include "dpfh_defs.svh"
module dma_periph_flow_handshake_tb import dpfh_pkg::*;;
	logic       clock, rst_n, ready, flow_is_dst, bus_ready;
	logic       busy, done, src_read, dst_write, descriptor_load;
	logic [1:0] sync;
	logic [7:0] remaining, fifo_level, discarded;
	int         num_errors, num_checks, n_rd, n_wr, n_ld, n_dn, cyc, lat, lat0;
	dpfh_if flow_if ();
	dpfh_if peer_if ();
	dpfh_periph #(.BURST_LEN(4)) dpfh_periph_i (.clock(clock), .rst_n(rst_n),
		.link(flow_if), .ready(ready), .remaining(remaining), .busy(busy), .done(done));
	dpfh_ctrl #(.BURST_LEN(4), .FIFO_DEPTH(16)) dpfh_ctrl_i (.clock(clock), .rst_n(rst_n),
		.flow(flow_if), .peer(peer_if), .flow_is_dst(flow_is_dst), .req_sync_select(sync),
		.bus_ready(bus_ready), .src_read(src_read), .dst_write(dst_write),
		.descriptor_load(descriptor_load), .fifo_level(fifo_level), .discarded(discarded));
	dpfh_chk dpfh_chk_i (.clock(clock), .rst_n(rst_n), .burst_req(flow_if.burst_req),
		.single_req(flow_if.single_req), .last_burst_req(flow_if.last_burst_req),
		.last_single_req(flow_if.last_single_req), .xfer_clear_ack(flow_if.xfer_clear_ack),
		.packet_terminal_count(flow_if.packet_terminal_count), .req_synced(sync[0]));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// Ceiling well above the two hundred or so cycles the tests take
	always @(posedge clock) begin
		cyc++;
		n_rd += src_read;
		n_wr += dst_write;
		n_ld += descriptor_load;
		n_dn += done;
		if (cyc == 3000) begin
			num_errors++;
			summarize();
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Raise a request once the previous one closed; wt also waits for this one
	task req(input logic [7:0] rem, input bit wt);
		int t;
		t = 0;
		@(negedge clock);
		while (busy !== 1'b0)
			@(negedge clock);
		remaining = rem;
		ready = 1'b1;
		while (busy !== 1'b1 && t < 50) begin
			@(negedge clock);
			t++;
		end
		ready = 1'b0;
		while (wt && busy !== 1'b0 && t < 200) begin
			@(negedge clock);
			t++;
		end
		lat = t;
	endtask : req
	task wait_ld(input int n);
		repeat (200) if (n_ld < n) @(negedge clock);
	endtask : wait_ld
	task summarize;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize
	initial begin
		{rst_n, ready, flow_is_dst, sync, remaining} = '0;
		bus_ready = 1'b1;
		{peer_if.burst_req, peer_if.single_req} = 2'h0;
		{peer_if.last_burst_req, peer_if.last_single_req} = 2'h0;
		{num_errors, num_checks, n_rd, n_wr, n_ld, n_dn, cyc} = '0;
		repeat (3) @(negedge clock);
		rst_n = 1'b1;
		req(8'h02, 1);
		lat0 = lat;
		// Sync select only changes once the acknowledge has fallen
		repeat (3) @(negedge clock);
		sync = 2'h1;
		req(8'h02, 1);
		chk(lat[7:0], lat0[7:0] + 8'h02);
		repeat (3) @(negedge clock);
		sync = 2'h0;
		for (int i = 0; i < 3; i++) req(8'h09, 1);
		chk(n_rd[7:0], 8'h0e);
		chk(fifo_level, 8'h0e);
		req(8'h09, 0);
		repeat (10) @(negedge clock);
		chk(n_rd[7:0], 8'h0e);
		peer_if.burst_req = 1'b1;
		req(8'h01, 1);
		wait_ld(1);
		repeat (3) @(negedge clock);
		chk(n_rd[7:0], 8'h13);
		chk(n_wr[7:0], 8'h13);
		chk(n_ld[7:0], 8'h01);
		chk(fifo_level, 8'h00);
		peer_if.burst_req = 1'b0;
		$display("test source flow done");
		flow_is_dst = 1'b1;
		sync = 2'h2;
		req(8'h03, 0);
		repeat (10) @(negedge clock);
		chk(n_rd[7:0], 8'h13);
		chk(n_wr[7:0], 8'h13);
		peer_if.burst_req = 1'b1;
		req(8'h00, 1);
		chk(n_rd[7:0], 8'h17);
		chk(fifo_level, 8'h03);
		req(8'h01, 1);
		wait_ld(2);
		repeat (3) @(negedge clock);
		peer_if.burst_req = 1'b0;
		chk(n_wr[7:0], 8'h15);
		chk(n_ld[7:0], 8'h02);
		chk(discarded, 8'h02);
		chk(fifo_level, 8'h00);
		chk(n_dn[7:0], 8'h04);
		$display("test destination flow done");
		summarize();
	end
endmodule : dma_periph_flow_handshake_tb
